// *** pkg/pts_defines.svh ***
/*
 * Constants for the protection trim select block: register indices,
 * field positions, reset values, trim defaults and threshold arithmetic.
 * Assumes it is included by bare name and that the APB byte address of a
 * register is four times its index.
 */
`ifndef PTS_DEFINES_SVH
`define PTS_DEFINES_SVH

// Register indices; the byte address is the index shifted left by two.
`define PTS_IDX_KEY_ADDR 16'h001D
`define PTS_IDX_GAIN 16'h001E
`define PTS_IDX_VOLT_TEMP 16'h001F
`define PTS_IDX_GATE_CTRL 16'h0010
`define PTS_IDX_STATUS 16'h0011
`define PTS_IDX_ADC_CFG 16'h600A

// Field positions.
`define PTS_KEY_MSB 7
`define PTS_KEY_LSB 0
`define PTS_ADDR_MSB 14
`define PTS_ADDR_LSB 8
`define PTS_HI_BYTE_MSB 15
`define PTS_HI_BYTE_LSB 8
`define PTS_LO_BYTE_MSB 7
`define PTS_LO_BYTE_LSB 0
`define PTS_UV_MSB 12
`define PTS_UV_LSB 8
`define PTS_TGE_BIT 7
`define PTS_TWS_MSB 6
`define PTS_TWS_LSB 5
`define PTS_OV_MSB 4
`define PTS_OV_LSB 0
`define PTS_CE_BIT 3
`define PTS_DE_BIT 2

// Key code that enables the user trim set.
`define PTS_KEY_ENABLE 8'h76

// Default trim values used whenever the key does not match.
`define PTS_DEF_SLAVE_ADDR 7'h0B
`define PTS_DEF_TEMPCO 8'h00
`define PTS_DEF_UV_CODE 5'h17
`define PTS_DEF_TWS 2'h0
`define PTS_DEF_TGE 1'h0
`define PTS_DEF_OV_CODE 5'h0A

// Reset values of the stored words.
`define PTS_RST_WORD 16'h0000
`define PTS_RST_GATE_CTRL 2'h0

// Threshold arithmetic in 10 uV units, gain in 0.001 %, tempco in 0.1 ppm/C.
`define PTS_OV_BASE 19'h67C28
`define PTS_OV_STEP 19'h003D1
`define PTS_UV_BASE 19'h46CD0
`define PTS_UV_STEP 19'h0079E
`define PTS_CE_OFFSET 19'h02710
`define PTS_GAIN_STEP 16'sh00C3
`define PTS_TEMPCO_STEP 16'h0131

// Temperature window table entries in degrees Celsius.
`define PTS_T_M43 8'hD5
`define PTS_T_M23 8'hE9
`define PTS_T_M3 8'hFD
`define PTS_T_53 8'h35
`define PTS_T_58 8'h3A
`define PTS_T_63 8'h3F
`define PTS_T_68 8'h44
`define PTS_T_73 8'h49
`define PTS_T_88 8'h58

`endif

// *** pkg/pts_pkg.sv ***
/*
 * Types shared by the protection trim select block.
 * Assumes the constants of pts_defines.svh are compiled alongside.
 */
package pts_pkg;
    // One stored trim or configuration word.
    typedef logic [15:0] pts_word_t;
    // Signed temperature in whole degrees Celsius.
    typedef logic signed [7:0] pts_temp_t;
    // Threshold voltage in 10 uV units.
    typedef logic [18:0] pts_volt_t;
    // Four temperature limits of one window.
    typedef struct packed {
        pts_temp_t chg_low;
        pts_temp_t chg_high;
        pts_temp_t dis_low;
        pts_temp_t dis_high;
    } pts_window_s;
endpackage

// *** design/pts_trim_select.sv ***
/*
 * Protection trim select: an APB slave holding three user trim words, the
 * ADC configuration word and a gate control word, the resolver that picks
 * the user or default trim set, and the gate drive for the charge and
 * discharge FETs.
 * Assumes the fault comparators and the pump reservoir monitor are
 * asynchronous to pclk, and the cell temperature comes from pclk logic.
 */
// Contract
// - Current and short-circuit limits come from ADC word.
// - Voltage and temperature limits come from trim.
// - Block discharge: discharge gate tied to ground.
// - Block charge: charge gate tied to supply.
// - Permit: gate pulled up to pump reservoir.
// - Three trim words are software rewritable.
// - Key 76h selects user trim, else defaults.
// - User or default trim switches as one set.
// - Slave address from bits 14:8 when keyed.
// - Upper byte is signed current gain trim.
// - Lower byte scales tempco, default zero.
// - Undervoltage code bits 12:8, default 17h.
// - Bit 7 gates temperature protection.
// - Bits 6:5 select the temperature window.
// - Overvoltage code bits 4:0, recovery 0.1V below.
`timescale 1ns/1ps
`include "pts_defines.svh"

module pts_trim_select #(
    parameter logic [7:0] FACTORY_GAIN_TRIM = 8'h00
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic trip_overvoltage,
    input wire logic trip_undervoltage,
    input wire logic trip_charge_overcurrent,
    input wire logic trip_discharge_overcurrent,
    input wire logic trip_short_circuit,
    input wire logic pump_reservoir_node,
    input wire pts_pkg::pts_temp_t cell_temp,
    output logic charge_gate_out,
    output logic discharge_gate_out,
    output logic user_trim_active,
    output logic [6:0] slave_address,
    output logic [7:0] current_gain_trim,
    output logic signed [15:0] gain_adjust_milli,
    output logic [7:0] shunt_tempco_trim,
    output logic [15:0] tempco_deci_ppm,
    output logic [4:0] low_cell_threshold_code,
    output logic [4:0] high_cell_threshold_code,
    output logic temp_guard_enable,
    output logic [1:0] temp_window_select,
    output pts_pkg::pts_volt_t uv_threshold,
    output pts_pkg::pts_volt_t ov_threshold,
    output pts_pkg::pts_volt_t ce_threshold,
    output pts_pkg::pts_word_t adc_config_word
);
    import pts_pkg::*;

    // Stored words written by software.
    pts_word_t key_addr_word;
    pts_word_t gain_word;
    pts_word_t volt_temp_word;
    logic [1:0] gate_ctrl;
    // Synchroniser stages for the six asynchronous inputs.
    logic [5:0] sync_a;
    logic [5:0] sync_b;

    // Byte addresses are four times the register index.
    wire [17:0] addr_key = {`PTS_IDX_KEY_ADDR, 2'b00};
    wire [17:0] addr_gain = {`PTS_IDX_GAIN, 2'b00};
    wire [17:0] addr_vt = {`PTS_IDX_VOLT_TEMP, 2'b00};
    wire [17:0] addr_gate = {`PTS_IDX_GATE_CTRL, 2'b00};
    wire [17:0] addr_stat = {`PTS_IDX_STATUS, 2'b00};
    wire [17:0] addr_adc = {`PTS_IDX_ADC_CFG, 2'b00};

    // Address decode.
    wire hit_key = (paddr == addr_key);
    wire hit_gain = (paddr == addr_gain);
    wire hit_vt = (paddr == addr_vt);
    wire hit_gate = (paddr == addr_gate);
    wire hit_stat = (paddr == addr_stat);
    wire hit_adc = (paddr == addr_adc);
    wire hit_any = hit_key | hit_gain | hit_vt | hit_gate | hit_stat | hit_adc;

    // Setup phase loads read data; access phase commits a write.
    wire setup_phase = psel & ~penable;
    wire write_commit = psel & penable & pwrite & hit_any;

    // The slave never inserts wait states.
    assign pready = 1'b1;
    // Unmapped addresses are answered with an error in the access phase.
    assign pslverr = psel & penable & ~hit_any;

    // Synchronised copies of the asynchronous inputs.
    wire ov_trip = sync_b[0];
    wire uv_trip = sync_b[1];
    wire coc_trip = sync_b[2];
    wire doc_trip = sync_b[3];
    wire sc_trip = sync_b[4];
    wire pump_ready = sync_b[5];

    // Key comparison decides the whole trim set at once.
    wire key_ok = (key_addr_word[`PTS_KEY_MSB:`PTS_KEY_LSB] == `PTS_KEY_ENABLE);

    // Next effective fields; one select steers every field together.
    wire [6:0] next_slave = key_ok ? key_addr_word[`PTS_ADDR_MSB:`PTS_ADDR_LSB]
                                   : `PTS_DEF_SLAVE_ADDR;
    wire [7:0] next_gain = key_ok ? gain_word[`PTS_HI_BYTE_MSB:`PTS_HI_BYTE_LSB]
                                  : FACTORY_GAIN_TRIM;
    wire [7:0] next_tempco = key_ok ? gain_word[`PTS_LO_BYTE_MSB:`PTS_LO_BYTE_LSB]
                                    : `PTS_DEF_TEMPCO;
    wire [4:0] next_uv = key_ok ? volt_temp_word[`PTS_UV_MSB:`PTS_UV_LSB]
                                : `PTS_DEF_UV_CODE;
    wire next_tge = key_ok ? volt_temp_word[`PTS_TGE_BIT] : `PTS_DEF_TGE;
    wire [1:0] next_tws = key_ok ? volt_temp_word[`PTS_TWS_MSB:`PTS_TWS_LSB]
                                 : `PTS_DEF_TWS;
    wire [4:0] next_ov = key_ok ? volt_temp_word[`PTS_OV_MSB:`PTS_OV_LSB]
                                : `PTS_DEF_OV_CODE;

    // Threshold arithmetic from the next codes, all in 10 uV units.
    wire [18:0] next_uv_v = 19'(`PTS_UV_BASE - 19'(next_uv) * `PTS_UV_STEP);
    wire [18:0] next_ov_v = 19'(`PTS_OV_BASE + 19'(next_ov) * `PTS_OV_STEP);
    wire [18:0] next_ce_v = 19'(next_ov_v - `PTS_CE_OFFSET);

    // Gain correction in 0.001 % steps, signed.
    wire signed [15:0] gain_ext = {{8{next_gain[7]}}, next_gain};
    wire signed [15:0] next_gain_milli = 16'(gain_ext * `PTS_GAIN_STEP);
    // Shunt tempco compensation in 0.1 ppm/C steps.
    wire [15:0] next_tempco_dp = 16'(16'(next_tempco) * `PTS_TEMPCO_STEP);

    // Temperature window lookup for the active select code.
    pts_window_s window;
    assign window = (temp_window_select == 2'h0) ?
                        {`PTS_T_M3, `PTS_T_53, `PTS_T_M23, `PTS_T_63} :
                    (temp_window_select == 2'h1) ?
                        {`PTS_T_M3, `PTS_T_58, `PTS_T_M23, `PTS_T_68} :
                    (temp_window_select == 2'h2) ?
                        {`PTS_T_M23, `PTS_T_73, `PTS_T_M23, `PTS_T_73} :
                        {`PTS_T_M43, `PTS_T_88, `PTS_T_M43, `PTS_T_88};

    // A limit only blocks when the guard is on; it is at or below low, or above high.
    wire chg_temp_block = temp_guard_enable &
        ((cell_temp <= window.chg_low) | (cell_temp > window.chg_high));
    wire dis_temp_block = temp_guard_enable &
        ((cell_temp <= window.dis_low) | (cell_temp > window.dis_high));

    // Charge is allowed only with no charge-side fault and a charged reservoir.
    wire next_chg = gate_ctrl[1] & pump_ready & ~ov_trip & ~uv_trip & ~coc_trip
                    & ~chg_temp_block;
    // Discharge is allowed only with no discharge-side fault and a charged reservoir.
    wire next_dis = gate_ctrl[0] & pump_ready & ~uv_trip & ~coc_trip & ~doc_trip
                    & ~sc_trip & ~dis_temp_block;

    // Read multiplexer; gate control reads back at bits 3:2 and upper bits read zero.
    wire [15:0] status_word = {user_trim_active, slave_address, 6'h00,
                               charge_gate_out, discharge_gate_out};
    wire [15:0] next_rd = hit_key ? key_addr_word :
                          hit_gain ? gain_word :
                          hit_vt ? volt_temp_word :
                          hit_gate ? {12'h000, gate_ctrl, 2'h0} :
                          hit_stat ? status_word :
                          hit_adc ? adc_config_word : 16'h0000;

    // Two-flop synchroniser; the first stage feeds only the second.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
        end else begin
            sync_a <= {pump_reservoir_node, trip_short_circuit, trip_discharge_overcurrent,
                       trip_charge_overcurrent, trip_undervoltage, trip_overvoltage};
            sync_b <= sync_a;
        end
    end

    // Stored trim words; software may rewrite them at any time.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_addr_word <= `PTS_RST_WORD;
            gain_word <= `PTS_RST_WORD;
            volt_temp_word <= `PTS_RST_WORD;
        end else if (write_commit) begin
            if (hit_key) begin
                key_addr_word <= pwdata[15:0];
            end
            if (hit_gain) begin
                gain_word <= pwdata[15:0];
            end
            if (hit_vt) begin
                volt_temp_word <= pwdata[15:0];
            end
        end
    end

    // ADC configuration word holding the current and short-circuit limits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_config_word <= `PTS_RST_WORD;
        end else if (write_commit && hit_adc) begin
            adc_config_word <= pwdata[15:0];
        end
    end

    // Gate control: bit 1 charge enable, bit 0 discharge enable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_ctrl <= `PTS_RST_GATE_CTRL;
        end else if (write_commit && hit_gate) begin
            gate_ctrl <= {pwdata[`PTS_CE_BIT], pwdata[`PTS_DE_BIT]};
        end
    end

    // Read data is captured in the setup phase and held through the access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase) begin
            prdata <= {16'h0000, next_rd};
        end
    end

    // Effective trim set, refreshed every cycle from the stored words.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_trim_active <= 1'b0;
            slave_address <= `PTS_DEF_SLAVE_ADDR;
            current_gain_trim <= FACTORY_GAIN_TRIM;
            shunt_tempco_trim <= `PTS_DEF_TEMPCO;
            low_cell_threshold_code <= `PTS_DEF_UV_CODE;
            temp_guard_enable <= `PTS_DEF_TGE;
            temp_window_select <= `PTS_DEF_TWS;
            high_cell_threshold_code <= `PTS_DEF_OV_CODE;
        end else begin
            user_trim_active <= key_ok;
            slave_address <= next_slave;
            current_gain_trim <= next_gain;
            shunt_tempco_trim <= next_tempco;
            low_cell_threshold_code <= next_uv;
            temp_guard_enable <= next_tge;
            temp_window_select <= next_tws;
            high_cell_threshold_code <= next_ov;
        end
    end

    // Derived thresholds and scale factors, registered with the fields.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_threshold <= 19'h00000;
            ov_threshold <= 19'h00000;
            ce_threshold <= 19'h00000;
            gain_adjust_milli <= 16'sh0000;
            tempco_deci_ppm <= 16'h0000;
        end else begin
            uv_threshold <= next_uv_v;
            ov_threshold <= next_ov_v;
            ce_threshold <= next_ce_v;
            gain_adjust_milli <= next_gain_milli;
            tempco_deci_ppm <= next_tempco_dp;
        end
    end

    // Gate drive: high pulls the gate to the reservoir, low ties it to its rail.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            charge_gate_out <= 1'b0;
            discharge_gate_out <= 1'b0;
        end else begin
            charge_gate_out <= next_chg;
            discharge_gate_out <= next_dis;
        end
    end

    // Checks, all on pclk with reset as disable.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_ADC_WRITE: assert property (
        (write_commit && hit_adc) |=> (adc_config_word == $past(pwdata[15:0])))
        else $error("ADC configuration word did not take the write");
    AST_OV_FROM_TRIM: assert property (
        (key_ok && $stable(volt_temp_word)) |=>
        (high_cell_threshold_code == $past(volt_temp_word[4:0])))
        else $error("Overvoltage code not taken from the trim word");
    AST_DIS_BLOCK: assert property (
        sc_trip |=> !discharge_gate_out)
        else $error("Discharge gate not tied low on short circuit");
    AST_CHG_BLOCK: assert property (
        (ov_trip || !gate_ctrl[1]) |=> !charge_gate_out)
        else $error("Charge gate not tied off on block");
    AST_PERMIT: assert property (
        (gate_ctrl[0] && pump_ready && !uv_trip && !coc_trip && !doc_trip
         && !sc_trip && !dis_temp_block) |=> discharge_gate_out)
        else $error("Discharge gate not pulled up when permitted");
    AST_TRIM_WRITE: assert property (
        (write_commit && hit_vt) |=> (volt_temp_word == $past(pwdata[15:0])))
        else $error("Trim word did not take the write");
    AST_DEFAULT_SET: assert property (
        !key_ok [*2] |-> (!user_trim_active && low_cell_threshold_code == 5'h17
                          && high_cell_threshold_code == 5'h0A))
        else $error("Default trim not used without key");
    AST_ONE_SET: assert property (
        (user_trim_active && $stable(key_addr_word) && $stable(gain_word)) |->
        (slave_address == key_addr_word[14:8] && current_gain_trim == gain_word[15:8]
         && shunt_tempco_trim == gain_word[7:0]))
        else $error("Mixed user and default trim");
    AST_SLAVE_DEF: assert property (
        (!key_ok ##1 !key_ok) |-> (slave_address == 7'h0B))
        else $error("Slave address default wrong");
    AST_GAIN_SCALE: assert property (
        $past(presetn) |->
        (gain_adjust_milli == 16'($signed(current_gain_trim) * 16'sh00C3)))
        else $error("Gain correction wrong");
    AST_UV_VALUE: assert property (
        presetn |=> (uv_threshold == 19'(19'h46CD0 - 19'($past(next_uv)) * 19'h0079E)))
        else $error("Undervoltage threshold wrong");
    AST_GUARD_OFF: assert property (
        !temp_guard_enable |-> (!chg_temp_block && !dis_temp_block))
        else $error("Temperature limits applied while guard off");
    AST_CE_GAP: assert property (
        $past(presetn) |-> ((ov_threshold - ce_threshold) == 19'h02710))
        else $error("Recovery threshold not 0.1 V below overvoltage");
    AST_FOLLOW: assert property (
        $changed(key_addr_word) |-> ##[1:2] (user_trim_active == key_ok))
        else $error("Effective trim did not follow the stored words");

    COV_KEY_ON: cover property ($rose(user_trim_active));
    COV_KEY_OFF: cover property ($fell(user_trim_active));
    COV_CHG_ON: cover property ($rose(charge_gate_out));
    COV_TEMP_BLOCK: cover property (dis_temp_block && gate_ctrl[0]);
endmodule

// *** tb/pts_fet_model.sv ***
/*
 * Behavioural model of the external charge and discharge FETs and the pump
 * reservoir capacitor. Assumes pump_ok is driven by the bench on pclk.
 */
`timescale 1ns/1ps

module pts_fet_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pump_ok,
    input wire logic charge_gate_out,
    input wire logic discharge_gate_out,
    output logic pump_reservoir_node,
    output logic charge_path_on,
    output logic discharge_path_on
);
    // Two-stage delay that stands for the reservoir charging up slowly.
    logic [1:0] fill;

    // The reservoir follows the pump two cycles late and is empty in reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill <= 2'h0;
        end else begin
            fill <= {fill[0], pump_ok};
        end
    end

    assign pump_reservoir_node = fill[1];
    // A FET conducts only while its gate is pulled to a charged reservoir.
    assign charge_path_on = charge_gate_out & pump_reservoir_node;
    assign discharge_path_on = discharge_gate_out & pump_reservoir_node;
endmodule

// *** tb/tb_pts_trim_select.sv ***
/*
 * Self-checking bench for the trim select block: APB master, random trim
 * words with key corners, fault and temperature stimulus, FET model.
 * Assumes pready answers within a few cycles and the design header exists.
 */
`timescale 1ns/1ps
`include "pts_defines.svh"

module tb_pts_trim_select;
    import pts_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0;
    logic [4:0] trips = 5'h0;
    logic pump_ok = 1'b0;
    pts_temp_t cell_temp = 8'h0;
    logic pready, pslverr, pump_node, chg, dis, user_on, guard;
    logic [31:0] prdata;
    logic [6:0] saddr;
    logic [7:0] gain, tempco;
    logic signed [15:0] gain_milli;
    logic [15:0] tempco_ppm;
    logic [4:0] uv_code, ov_code;
    logic [1:0] window;
    pts_volt_t uv_thr, ov_thr, ce_thr;
    pts_word_t adc_word;
    int err_count = 0;
    int comparisons = 0;
    // Temperature limits per window: charge low, charge high, discharge low, high.
    int lims [4][4] = '{'{-3, 53, -23, 63}, '{-3, 58, -23, 68}, '{-23, 73, -23, 73},
        '{-43, 88, -43, 88}};

    always #50 pclk = ~pclk;

    pts_trim_select dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .trip_overvoltage(trips[4]), .trip_undervoltage(trips[3]),
        .trip_charge_overcurrent(trips[2]), .trip_discharge_overcurrent(trips[1]),
        .trip_short_circuit(trips[0]), .pump_reservoir_node(pump_node),
        .cell_temp(cell_temp), .charge_gate_out(chg), .discharge_gate_out(dis),
        .user_trim_active(user_on), .slave_address(saddr), .current_gain_trim(gain),
        .gain_adjust_milli(gain_milli), .shunt_tempco_trim(tempco),
        .tempco_deci_ppm(tempco_ppm), .low_cell_threshold_code(uv_code),
        .high_cell_threshold_code(ov_code), .temp_guard_enable(guard),
        .temp_window_select(window), .uv_threshold(uv_thr), .ov_threshold(ov_thr),
        .ce_threshold(ce_thr), .adc_config_word(adc_word));

    pts_fet_model fet_u (.pclk(pclk), .presetn(presetn), .pump_ok(pump_ok),
        .charge_gate_out(chg), .discharge_gate_out(dis), .pump_reservoir_node(pump_node),
        .charge_path_on(), .discharge_path_on());

    // Prints the verdict and stops the run.
    task automatic end_of_test;
        if (err_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one and reports a mismatch.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; entered just after a rising edge, leaves after one.
    task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            end_of_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Works out every effective trim output from the three stored words; tempco_deci_ppm only for tempco codes up to D6h.
    task automatic check_trim(input logic [15:0] w0, input logic [15:0] w1,
            input logic [15:0] w2);
        logic u;
        logic [7:0] g;
        logic [7:0] t;
        logic [4:0] uv;
        logic [4:0] ov;
        u = (w0[7:0] === 8'h76);
        g = u ? w1[15:8] : 8'h00;
        t = u ? w1[7:0] : 8'h00;
        uv = u ? w2[12:8] : 5'h17;
        ov = u ? w2[4:0] : 5'h0A;
        chk(user_on, u);
        chk(saddr, u ? w0[14:8] : 7'h0B);
        chk(gain, g);
        chk(gain_milli, 16'($signed(g) * 32'shC3));
        chk(tempco, t);
        if (t <= 8'hD6) chk(tempco_ppm, t * 32'h131);
        chk(uv_code, uv);
        chk(uv_thr, 32'h46CD0 - 32'h79E * uv);
        chk(ov_code, ov);
        chk(ov_thr, 32'h67C28 + 32'h3D1 * ov);
        chk(ce_thr, 32'h67C28 + 32'h3D1 * ov - 32'h2710);
        chk(guard, u & w2[7]);
        chk(window, u ? w2[6:5] : 2'h0);
    endtask

    // Expected {charge, discharge} gate levels from controls, faults and temperature.
    function automatic logic [1:0] exp_gates(logic [15:0] w0, logic [15:0] w2,
            logic [3:0] ctl, logic pump, int tc);
        logic g;
        logic cok;
        logic dok;
        int w;
        g = (w0[7:0] == 8'h76) && w2[7];
        w = w2[6:5];
        cok = !g || (tc > lims[w][0] && tc <= lims[w][1]);
        dok = !g || (tc > lims[w][2] && tc <= lims[w][3]);
        return {ctl[3] & pump & !trips[4] & !trips[3] & !trips[2] & cok,
            ctl[2] & pump & !trips[3] & !trips[2] & !trips[1] & !trips[0] & dok};
    endfunction

    initial begin
        logic [31:0] rd;
        logic er;
        logic [15:0] w0;
        logic [15:0] w1;
        logic [15:0] w2;
        logic [3:0] ctl;
        logic [7:0] keys [5];
        logic [1:0] ge;
        int tc;
        keys = '{8'h76, 8'h75, 8'h77, 8'hF6, 8'h00};
        void'($urandom(32'h93A5DD86));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check_trim(16'h0, 16'h0, 16'h0);
        chk({chg, dis}, 2'h0);
        apb(1'b0, 18'h80, 32'h0, rd, er);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        for (int i = 0; i < 60; i++) begin
            w0 = 16'($urandom);
            w1 = 16'($urandom);
            w2 = 16'($urandom);
            if (i % 2 == 0) w0[7:0] = keys[$urandom % 5];
            ctl = 4'($urandom);
            apb(1'b1, {`PTS_IDX_KEY_ADDR, 2'b00}, {16'hFFFF, w0}, rd, er);
            apb(1'b1, {`PTS_IDX_GAIN, 2'b00}, {16'h0, w1}, rd, er);
            apb(1'b1, {`PTS_IDX_VOLT_TEMP, 2'b00}, {16'h0, w2}, rd, er);
            apb(1'b1, {`PTS_IDX_GATE_CTRL, 2'b00}, {28'h0, ctl}, rd, er);
            tc = lims[w2[6:5]][$urandom % 4] + int'($urandom % 3) - 1;
            trips <= 5'($urandom & $urandom & $urandom);
            pump_ok <= ($urandom % 8 != 0);
            cell_temp <= tc[7:0];
            repeat (8) @(posedge pclk);
            check_trim(w0, w1, w2);
            ge = exp_gates(w0, w2, ctl, pump_ok, tc);
            chk({chg, dis}, ge);
            apb(1'b0, {`PTS_IDX_KEY_ADDR, 2'b00}, 32'h0, rd, er);
            chk(rd, {16'h0, w0});
            chk(er, 1'b0);
            apb(1'b0, {`PTS_IDX_STATUS, 2'b00}, 32'h0, rd, er);
            chk(rd & 32'hFF03, {w0[7:0] == 8'h76,
                ((w0[7:0] == 8'h76) ? w0[14:8] : 7'h0B), 6'h0, ge});
        end
        w0 = 16'($urandom);
        apb(1'b1, {`PTS_IDX_ADC_CFG, 2'b00}, {16'h0, w0}, rd, er);
        repeat (2) @(posedge pclk);
        chk(adc_word, w0);
        // A mid-run reset must clear the stored words and bring back the default set.
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check_trim(16'h0, 16'h0, 16'h0);
        chk(adc_word, 16'h0);
        chk({chg, dis}, 2'h0);
        end_of_test();
    end
endmodule
